/* verilog/adcc_params.svh */
// Register offsets, field positions, reset values and timing of adcc.
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH
`define ADCC_OFF_CONVERSION_CONTROL_B 8'h04
`define ADCC_OFF_WINDOW_MONITOR_CONTROL 8'h08
`define ADCC_OFF_SOFTWARE_TRIGGER 8'h0C
`define ADCC_OFF_INCTRL 8'h10
`define ADCC_OFF_WINDOW_LOWER_THRESHOLD 8'h18
`define ADCC_OFF_WINDOW_UPPER_THRESHOLD 8'h1C
`define ADCC_OFF_GAIN_CALIBRATION_VALUE 8'h20
`define ADCC_OFF_OFFCAL 8'h24
`define ADCC_OFF_RESULT 8'h28
`define ADCC_OFF_INTFLAG 8'h2C
`define ADCC_OFF_INTMASK 8'h30
`define ADCC_MASK_CONVERSION_CONTROL_B 32'h0000_073F
`define ADCC_MASK_WINDOW_MONITOR_CONTROL 32'h0000_0007
`define ADCC_MASK_INCTRL 32'h0FFF_1F1F
`define ADCC_MASK_HALF 32'h0000_FFFF
`define ADCC_MASK_CAL 32'h0000_0FFF
`define ADCC_RST_CONVERSION_CONTROL_B 11'h000
`define ADCC_RST_WINDOW_MONITOR_CONTROL 3'h0
`define ADCC_RST_INCTRL 32'h0000_0000
`define ADCC_RST_GAIN_CALIBRATION_VALUE 12'h800
`define ADCC_RST_OFFCAL 12'h000
`define ADCC_RST_THRESH 16'h0000
`define ADCC_PRESC_LSB 8
`define ADCC_RESOLUTION_SELECT_LSB 4
`define ADCC_DIGITAL_CORRECTION_ON_BIT 3
`define ADCC_CONTINUOUS_CONVERSION_BIT 2
`define ADCC_LEFT_BIT 1
`define ADCC_DIFF_BIT 0
`define ADCC_START_BIT 1
`define ADCC_FLUSH_BIT 0
`define ADCC_GAIN_LSB 24
`define ADCC_OFFS_LSB 20
`define ADCC_SCAN_LSB 16
`define ADCC_NEGATIVE_INPUT_SELECT_LSB 8
`define ADCC_POSITIVE_INPUT_SELECT_LSB 0
`define ADCC_DIV_BASE 10'h004
`define ADCC_CORR_EXTRA 5'h02
`define ADCC_LAST_PIN 5'h13
`define ADCC_FIRST_INT 5'h18
`define ADCC_LAST_INT 5'h1C
`define ADCC_GAIN_MAX 4'h4
`define ADCC_GAIN_HALF 4'hF
`endif

/* verilog/adcc_pkg.sv */
// Types shared by the adcc conversion control block.
package adcc_pkg;
  typedef enum logic [1:0] {ADCC_IDLE, ADCC_CONV, ADCC_DONE} adcc_state_e;
  typedef enum logic [1:0] {ADCC_RES12, ADCC_RES16, ADCC_RES10,
                            ADCC_RES8} adcc_res_e;
  typedef enum logic [2:0] {ADCC_WIN_OFF, ADCC_WIN_ABOVE, ADCC_WIN_BELOW,
                            ADCC_WIN_INSIDE, ADCC_WIN_OUTSIDE} adcc_win_e;
  typedef logic [15:0] adcc_result_t;
endpackage

/* verilog/adcc_ctrl.sv */
// ADC conversion control with an AXI4-Lite register slave.
// Function
// (RULE1) Converter clock is peripheral clock divided by 4 shl prescaler code.
// (RULE2) Resolution code 0..3 gives 12, 16, 10 and 8 bit results.
// (RULE3) Correction applies offset and gain and adds offset-dependent ticks; 16-bit results are left uncorrected.
// (RULE4) Free-running relaunches after each conversion; else one per trigger.
// (RULE5) Left alignment puts the result in the top bits; right is default.
// (RULE6) Differential mode converts positive minus negative input.
// (RULE7) Window code 0 off, 1 above lower, 2 below upper threshold.
// (RULE8) Window code 3 strictly inside, 4 outside; 5 to 7 reserved.
// (RULE9) Writing start one launches; hardware clears it; other writes ignored.
// (RULE10) Flush restarts converter clock and aborts conversions in progress.
// (RULE11) After flush a pending or aborted conversion is launched afresh.
// (RULE12) Gain code 0..4 is 1x to 16x, 0xF is half, rest reserved.
// (RULE13) Positive input is base selection plus scan offset.
// (RULE14) Scan offset steps by one after each conversion.
// (RULE15) Scanning is on for nonzero count and covers count plus one inputs.
// (RULE16) Software keeps the scanned range within the present channels.
// (RULE17) Unused bits read zero and are never stored.
// (RULE18) Positive codes 0x00-0x13 are pins, 0x18-0x1C internal sources.
// (RULE19) Each new result is checked against the window condition.
`timescale 1ns/1ps
`include "adcc_params.svh"
module adcc_ctrl
  import adcc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] convData,
  output logic convClkEn,
  output logic convStart,
  output logic [4:0] positiveInputSelect,
  output logic [4:0] negativeInputSelect,
  output logic differentialInputSelect,
  output logic [3:0] gainStageSel,
  output logic gainStageValid,
  output logic posIsPin,
  output logic posIsInternal,
  output logic windowHit,
  output logic irq
);
  if (ADDR_W < 6 || ADDR_W > 32) begin : g_chk
    $error("adcc_ctrl: ADDR_W must lie in 6..32");
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic awReady_q, wReady_q, bValid_q, arReady_q, rValid_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic [31:0] wData_q, rData_q, rdVal, wBytes;
  logic [3:0] wStrb_q;
  logic [1:0] bResp_q, rResp_q;
  logic wrFire, rdOk, wrOk;
  logic wCtrlB, wWin, wSw, wIn, wLt, wUt, wGc, wOc, wFlag, wMsk;

  assign wrFire = !awReady_q && !wReady_q && !bValid_q;

  // Address and data are caught independently, so either may come first.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      awReady_q <= 1'b1;
      wReady_q <= 1'b1;
      awAddr_q <= '0;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && awReady_q) begin
        awAddr_q <= s_axi_awaddr;
        awReady_q <= 1'b0;
      end else if (wrFire) begin
        awReady_q <= 1'b1;
      end
      if (s_axi_wvalid && wReady_q) begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
        wReady_q <= 1'b0;
      end else if (wrFire) begin
        wReady_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bValid_q <= 1'b0;
      bResp_q <= 2'h0;
    end else if (wrFire) begin
      bValid_q <= 1'b1;
      bResp_q <= wrOk ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      bValid_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      arReady_q <= 1'b1;
      rValid_q <= 1'b0;
      rData_q <= 32'h0000_0000;
      rResp_q <= 2'h0;
    end else if (s_axi_arvalid && arReady_q) begin
      arReady_q <= 1'b0;
      rValid_q <= 1'b1;
      rData_q <= rdVal;
      rResp_q <= rdOk ? 2'h0 : 2'h2;
    end else if (rValid_q && s_axi_rready) begin
      rValid_q <= 1'b0;
      arReady_q <= 1'b1;
    end
  end

  assign s_axi_awready = awReady_q;
  assign s_axi_wready = wReady_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;

  assign wBytes = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}},
                   {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
  assign wCtrlB = wrFire && awAddr_q == ADDR_W'(`ADCC_OFF_CONVERSION_CONTROL_B);
  assign wWin = wrFire && awAddr_q == ADDR_W'(`ADCC_OFF_WINDOW_MONITOR_CONTROL);
  assign wSw = wrFire && awAddr_q == ADDR_W'(`ADCC_OFF_SOFTWARE_TRIGGER);
  assign wIn = wrFire && awAddr_q == ADDR_W'(`ADCC_OFF_INCTRL);
  assign wLt = wrFire && awAddr_q == ADDR_W'(`ADCC_OFF_WINDOW_LOWER_THRESHOLD);
  assign wUt = wrFire && awAddr_q == ADDR_W'(`ADCC_OFF_WINDOW_UPPER_THRESHOLD);
  assign wGc = wrFire && awAddr_q == ADDR_W'(`ADCC_OFF_GAIN_CALIBRATION_VALUE);
  assign wOc = wrFire && awAddr_q == ADDR_W'(`ADCC_OFF_OFFCAL);
  assign wFlag = wrFire && awAddr_q == ADDR_W'(`ADCC_OFF_INTFLAG);
  assign wMsk = wrFire && awAddr_q == ADDR_W'(`ADCC_OFF_INTMASK);
  assign wrOk = wCtrlB || wWin || wSw || wIn || wLt || wUt || wGc || wOc
                || wFlag || wMsk
                || awAddr_q == ADDR_W'(`ADCC_OFF_RESULT);

  // Only bits inside the field mask are ever stored, so reserved bits
  // read back as zero whatever software writes.
  function automatic logic [31:0] mrg(input logic [31:0] old,
                                      input logic [31:0] fm);
    mrg = (old & ~(wBytes & fm)) | (wData_q & wBytes & fm); // RULE17
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [10:0] conversion_control_b_q;
  logic [2:0] window_monitor_control_q;
  logic [31:0] inCtrl_q, inNew;
  logic [15:0] winLow_q, winUp_q;
  logic [11:0] gain_calibration_value_q, offCal_q;
  logic [3:0] scanStart_q;
  logic startBit_q, flushBusy_q, flushPulse;
  adcc_result_t result_q;
  logic [1:0] flags_q, flags_d, mask_q;

  logic [2:0] prescaler;
  adcc_res_e resolutionSelect;
  logic digitalCorrectionOn, continuousConversion, resultAlignHigh;
  logic differentialSel;
  adcc_win_e windowCheckSelect;
  logic [3:0] scanPositionOffset, scanChannelCount;

  assign prescaler = conversion_control_b_q[`ADCC_PRESC_LSB +: 3];
  assign resolutionSelect = adcc_res_e'(conversion_control_b_q[`ADCC_RESOLUTION_SELECT_LSB +: 2]);
  assign digitalCorrectionOn = conversion_control_b_q[`ADCC_DIGITAL_CORRECTION_ON_BIT];
  assign continuousConversion = conversion_control_b_q[`ADCC_CONTINUOUS_CONVERSION_BIT];
  assign resultAlignHigh = conversion_control_b_q[`ADCC_LEFT_BIT];
  assign differentialSel = conversion_control_b_q[`ADCC_DIFF_BIT];
  assign windowCheckSelect = adcc_win_e'(window_monitor_control_q);
  assign scanPositionOffset = inCtrl_q[`ADCC_OFFS_LSB +: 4];
  assign scanChannelCount = inCtrl_q[`ADCC_SCAN_LSB +: 4];
  assign inNew = mrg(inCtrl_q, `ADCC_MASK_INCTRL);
  assign flushPulse = wSw && wData_q[`ADCC_FLUSH_BIT] && wStrb_q[0];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      conversion_control_b_q <= `ADCC_RST_CONVERSION_CONTROL_B;
      window_monitor_control_q <= `ADCC_RST_WINDOW_MONITOR_CONTROL;
      winLow_q <= `ADCC_RST_THRESH;
      winUp_q <= `ADCC_RST_THRESH;
      gain_calibration_value_q <= `ADCC_RST_GAIN_CALIBRATION_VALUE;
      offCal_q <= `ADCC_RST_OFFCAL;
      mask_q <= 2'h0;
    end else begin
      if (wCtrlB)
        conversion_control_b_q <= 11'(mrg(32'(conversion_control_b_q), `ADCC_MASK_CONVERSION_CONTROL_B));
      if (wWin)
        window_monitor_control_q <= 3'(mrg(32'(window_monitor_control_q), `ADCC_MASK_WINDOW_MONITOR_CONTROL));
      if (wLt)
        winLow_q <= 16'(mrg(32'(winLow_q), `ADCC_MASK_HALF));
      if (wUt)
        winUp_q <= 16'(mrg(32'(winUp_q), `ADCC_MASK_HALF));
      if (wGc)
        gain_calibration_value_q <= 12'(mrg(32'(gain_calibration_value_q), `ADCC_MASK_CAL));
      if (wOc)
        offCal_q <= 12'(mrg(32'(offCal_q), `ADCC_MASK_CAL));
      if (wMsk)
        mask_q <= 2'(mrg(32'(mask_q), 32'h0000_0003));
    end
  end

  always_comb begin
    rdVal = 32'h0000_0000;
    rdOk = 1'b1;
    case (s_axi_araddr)
      ADDR_W'(`ADCC_OFF_CONVERSION_CONTROL_B): rdVal = 32'(conversion_control_b_q);
      ADDR_W'(`ADCC_OFF_WINDOW_MONITOR_CONTROL): rdVal = 32'(window_monitor_control_q);
      ADDR_W'(`ADCC_OFF_SOFTWARE_TRIGGER): rdVal = {30'h0, startBit_q, flushBusy_q};
      ADDR_W'(`ADCC_OFF_INCTRL): rdVal = inCtrl_q;
      ADDR_W'(`ADCC_OFF_WINDOW_LOWER_THRESHOLD): rdVal = 32'(winLow_q);
      ADDR_W'(`ADCC_OFF_WINDOW_UPPER_THRESHOLD): rdVal = 32'(winUp_q);
      ADDR_W'(`ADCC_OFF_GAIN_CALIBRATION_VALUE): rdVal = 32'(gain_calibration_value_q);
      ADDR_W'(`ADCC_OFF_OFFCAL): rdVal = 32'(offCal_q);
      ADDR_W'(`ADCC_OFF_RESULT): rdVal = 32'(result_q);
      ADDR_W'(`ADCC_OFF_INTFLAG): rdVal = 32'(flags_q);
      ADDR_W'(`ADCC_OFF_INTMASK): rdVal = 32'(mask_q);
      default: rdOk = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Converter clock prescaler
  // ----------------------------------------------------------------
  logic [9:0] divCnt_q, divMax;
  logic convTick;

  assign divMax = (`ADCC_DIV_BASE << prescaler) - 10'h001; // RULE1
  // Comparing with >= lets a smaller prescaler take effect at once instead
  // of letting the counter run all the way round first.
  assign convTick = divCnt_q >= divMax;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      divCnt_q <= 10'h000;
    else if (flushPulse || convTick)
      divCnt_q <= 10'h000; // RULE10
    else
      divCnt_q <= divCnt_q + 10'h001;
  end

  // ----------------------------------------------------------------
  // Conversion sequencing
  // ----------------------------------------------------------------
  adcc_state_e state_q;
  logic [4:0] tickCnt_q, convTicks, resBits;
  logic relaunch_q, launch, doneNow, scanActive;
  logic [4:0] posSel;

  assign launch = state_q == ADCC_IDLE && (startBit_q || relaunch_q)
                  && !flushPulse;
  assign doneNow = state_q == ADCC_DONE && !flushPulse;

  always_comb begin
    case (resolutionSelect) // RULE2
      ADCC_RES16: resBits = 5'd16;
      ADCC_RES10: resBits = 5'd10;
      ADCC_RES8: resBits = 5'd8;
      default: resBits = 5'd12;
    endcase
    convTicks = resBits;
    if (digitalCorrectionOn)
      convTicks = resBits + `ADCC_CORR_EXTRA + 5'(offCal_q[1:0]); // RULE3
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ADCC_IDLE;
      tickCnt_q <= 5'h00;
    end else if (flushPulse) begin
      state_q <= ADCC_IDLE; // RULE10
    end else begin
      case (state_q)
        ADCC_IDLE: begin
          if (launch) begin
            state_q <= ADCC_CONV;
            tickCnt_q <= convTicks;
          end
        end
        ADCC_CONV: begin
          if (convTick) begin
            if (tickCnt_q == 5'h01)
              state_q <= ADCC_DONE;
            else
              tickCnt_q <= tickCnt_q - 5'h01;
          end
        end
        default: state_q <= ADCC_IDLE;
      endcase
    end
  end

  // A start written while the bit is still set is dropped on purpose.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      startBit_q <= 1'b0;
    else if (wSw && wData_q[`ADCC_START_BIT] && wStrb_q[0] && !startBit_q)
      startBit_q <= 1'b1; // RULE9
    else if (launch)
      startBit_q <= 1'b0; // RULE9
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      relaunch_q <= 1'b0;
      flushBusy_q <= 1'b0;
    end else begin
      flushBusy_q <= flushPulse;
      if (flushPulse)
        relaunch_q <= relaunch_q || state_q != ADCC_IDLE; // RULE11
      else if (launch)
        relaunch_q <= 1'b0;
      else if (doneNow && continuousConversion)
        relaunch_q <= 1'b1; // RULE4
    end
  end

  // ----------------------------------------------------------------
  // Input selection and scan
  // ----------------------------------------------------------------
  assign scanActive = scanChannelCount != 4'h0; // RULE15
  assign posSel = inCtrl_q[`ADCC_POSITIVE_INPUT_SELECT_LSB +: 5]
                  + 5'(scanPositionOffset); // RULE13

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      inCtrl_q <= `ADCC_RST_INCTRL;
      scanStart_q <= 4'h0;
    end else if (wIn) begin
      inCtrl_q <= inNew;
      scanStart_q <= inNew[`ADCC_OFFS_LSB +: 4];
    end else if (doneNow && scanActive) begin
      // Wrap after count plus one inputs back to the programmed offset.
      if (scanPositionOffset - scanStart_q == scanChannelCount) // RULE15
        inCtrl_q[`ADCC_OFFS_LSB +: 4] <= scanStart_q;
      else
        inCtrl_q[`ADCC_OFFS_LSB +: 4] <= scanPositionOffset + 4'h1; // RULE14
    end
  end

  // Mux settings are frozen at launch so a register write cannot
  // disturb a conversion that is already sampling.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      convStart <= 1'b0;
      convClkEn <= 1'b0;
      positiveInputSelect <= 5'h00;
      negativeInputSelect <= 5'h00;
      differentialInputSelect <= 1'b0;
      gainStageSel <= 4'h0;
      gainStageValid <= 1'b1;
      posIsPin <= 1'b1;
      posIsInternal <= 1'b0;
    end else begin
      convStart <= launch;
      convClkEn <= convTick && !flushPulse;
      if (launch) begin
        positiveInputSelect <= posSel;
        negativeInputSelect <= inCtrl_q[`ADCC_NEGATIVE_INPUT_SELECT_LSB +: 5];
        differentialInputSelect <= differentialSel; // RULE6
        gainStageSel <= inCtrl_q[`ADCC_GAIN_LSB +: 4];
        gainStageValid <= inCtrl_q[`ADCC_GAIN_LSB +: 4] <= `ADCC_GAIN_MAX
          || inCtrl_q[`ADCC_GAIN_LSB +: 4] == `ADCC_GAIN_HALF; // RULE12
        posIsPin <= posSel <= `ADCC_LAST_PIN; // RULE18
        posIsInternal <= posSel >= `ADCC_FIRST_INT
                         && posSel <= `ADCC_LAST_INT; // RULE18
      end
    end
  end

  // ----------------------------------------------------------------
  // Result path and window monitor
  // ----------------------------------------------------------------
  logic [15:0] rawA_q, rawB_q;
  logic signed [13:0] offDiff;
  logic [11:0] clip12, corr12, val12;
  logic [23:0] prod;
  adcc_result_t newRes;
  logic winMatch;

  // The converter output comes from the analog side and is held stable
  // through the done state, so a plain two-stage capture suffices.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rawA_q <= 16'h0000;
      rawB_q <= 16'h0000;
    end else begin
      rawA_q <= convData;
      rawB_q <= rawA_q;
    end
  end

  always_comb begin
    offDiff = $signed({2'b00, rawB_q[11:0]})
              - $signed({{2{offCal_q[11]}}, offCal_q});
    if (offDiff < 0)
      clip12 = 12'h000;
    else if (offDiff > 14'sd4095)
      clip12 = 12'hFFF;
    else
      clip12 = offDiff[11:0];
    prod = 24'(clip12) * 24'(gain_calibration_value_q);
    corr12 = prod[23] ? 12'hFFF : prod[22:11];
    val12 = digitalCorrectionOn ? corr12 : rawB_q[11:0]; // RULE3
    case (resolutionSelect) // RULE2
      ADCC_RES16: newRes = rawB_q;
      ADCC_RES10: newRes = resultAlignHigh ? {val12[11:2], 6'h00}
                                           : {6'h00, val12[11:2]};
      ADCC_RES8: newRes = resultAlignHigh ? {val12[11:4], 8'h00}
                                          : {8'h00, val12[11:4]};
      default: newRes = resultAlignHigh ? {val12, 4'h0}
                                        : {4'h0, val12}; // RULE5
    endcase
    case (windowCheckSelect)
      ADCC_WIN_ABOVE: winMatch = newRes > winLow_q; // RULE7
      ADCC_WIN_BELOW: winMatch = newRes < winUp_q; // RULE7
      ADCC_WIN_INSIDE: winMatch = newRes > winLow_q
                                  && newRes < winUp_q; // RULE8
      ADCC_WIN_OUTSIDE: winMatch = !(newRes > winLow_q
                                     && newRes < winUp_q); // RULE8
      default: winMatch = 1'b0;
    endcase
  end

  // Flag bit 0 is result ready, bit 1 window hit; a new event beats a
  // write-one-to-clear in the same cycle.
  always_comb begin
    flags_d = flags_q;
    if (wFlag)
      flags_d = flags_q & ~(wData_q[1:0] & {2{wStrb_q[0]}});
    if (doneNow)
      flags_d = flags_d | {winMatch, 1'b1}; // RULE19
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      result_q <= 16'h0000;
      flags_q <= 2'h0;
      windowHit <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (doneNow)
        result_q <= newRes;
      flags_q <= flags_d;
      windowHit <= doneNow && winMatch; // RULE19
      irq <= |(flags_d & (wMsk ? 2'(mrg(32'(mask_q), 32'h3)) : mask_q));
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  logic [9:0] gap_q;
  logic gapClean_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_q <= 10'h000;
      gapClean_q <= 1'b0;
    end else begin
      gap_q <= convClkEn ? 10'h000 : gap_q + 10'h001;
      gapClean_q <= (gapClean_q || convClkEn) && !flushPulse && !wCtrlB;
    end
  end

  a_presc_period: assert property ( // RULE1
    convClkEn && gapClean_q
    |-> 11'(gap_q) + 11'h001 == (11'h004 << prescaler))
    else $error("converter clock period wrong");
  a_start_clears: assert property ( // RULE9
    launch && !wSw |=> !startBit_q && state_q == ADCC_CONV)
    else $error("start bit not cleared at launch");
  a_start_launch: assert property ( // RULE9
    state_q == ADCC_IDLE && startBit_q && !flushPulse |=> convStart)
    else $error("pending start did not launch");
  a_flush_abort: assert property ( // RULE10
    flushPulse |=> state_q == ADCC_IDLE && divCnt_q == 10'h000)
    else $error("flush did not abort");
  a_flush_resume: assert property ( // RULE11
    flushPulse && state_q == ADCC_CONV ##1 !flushPulse |=> convStart)
    else $error("no relaunch after flush");
  a_free_run: assert property ( // RULE4
    doneNow && continuousConversion ##1 !flushPulse[*2] |-> convStart)
    else $error("free running did not relaunch");
  a_win_above: assert property ( // RULE7
    doneNow && windowCheckSelect == ADCC_WIN_ABOVE
    && newRes > winLow_q |=> windowHit && flags_q[1])
    else $error("window above missed");
  a_left_align: assert property ( // RULE5
    doneNow && resolutionSelect == ADCC_RES12 && resultAlignHigh
    |=> result_q[3:0] == 4'h0 && result_q[15:4] == $past(val12))
    else $error("left alignment wrong");
  a_scan_step: assert property ( // RULE14
    doneNow && scanActive && !wIn
    && scanPositionOffset - scanStart_q != scanChannelCount
    |=> scanPositionOffset == $past(scanPositionOffset) + 4'h1)
    else $error("scan offset did not step");
  a_irq_level: assert property (
    irq == |(flags_q & mask_q))
    else $error("interrupt level wrong");

  c_free_two: cover property (
    doneNow && continuousConversion ##[1:300] doneNow);
  c_flush_conv: cover property (flushPulse && state_q == ADCC_CONV);
  c_win_hit: cover property (windowHit && flags_q[1] == 1'b0);
  c_scan_wrap: cover property (
    doneNow && scanActive
    && scanPositionOffset - scanStart_q == scanChannelCount);
endmodule

/* verification/test_adc_conversion_control.sv */
// Self-checking testbench of the adcc conversion control block.
`timescale 1ns/1ps
`include "adcc_params.svh"
module test_adc_conversion_control;
  import adcc_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] r; logic [31:0] e;} adcc_row_s;
  logic sys_clk = 1'h0;
  logic rst_b = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [15:0] convData = 16'h0800;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, convClkEn, convStart, differentialInputSelect;
  logic gainStageValid, posIsPin, posIsInternal, windowHit, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd;
  logic [3:0] gainStageSel;
  logic [4:0] positiveInputSelect, negativeInputSelect;
  logic [4:0] hit = 5'h14;
  int miscompares = 0;
  int samplesChecked = 0;
  int n;
  adcc_row_s rows[6] = '{
    '{`ADCC_OFF_CONVERSION_CONTROL_B, 32'h0, 32'h73F}, '{`ADCC_OFF_WINDOW_MONITOR_CONTROL, 32'h0, 32'h7},
    '{`ADCC_OFF_INCTRL, 32'h0, 32'h0FFF1F1F},
    '{`ADCC_OFF_WINDOW_UPPER_THRESHOLD, 32'h0, 32'hFFFF},
    '{`ADCC_OFF_GAIN_CALIBRATION_VALUE, 32'h800, 32'hFFF},
    '{`ADCC_OFF_OFFCAL, 32'h0, 32'hFFF}};

  adcc_ctrl dut (.*);

  always #2.5 sys_clk = ~sys_clk;

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    if (g !== e) begin
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
      miscompares++;
    end
    samplesChecked++;
  endtask

  // Channels are sampled at the falling edge, so the decision matches the
  // rising edge that follows and never races the design's own updates.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    tb = 1'h0;
    while (!tb) begin
      @(negedge sys_clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge sys_clk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
  endtask

  task automatic rdr(input logic [7:0] a);
    logic ta, tr;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    tr = 1'h0;
    while (!tr) begin
      @(negedge sys_clk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge sys_clk);
      if (ta) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
  endtask

  // Interrupt time is bounded both ways: too early means a flush did not abort.
  task automatic conv(input logic fl);
    wr(`ADCC_OFF_SOFTWARE_TRIGGER, 32'h2);
    if (fl) begin
      repeat (20) @(posedge sys_clk);
      wr(`ADCC_OFF_SOFTWARE_TRIGGER, 32'h1);
    end
    n = 0;
    while (irq !== 1'h1 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    chk({31'h0, n >= 120 && n <= 140}, 32'h1);
  endtask

  task automatic summarize;
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge sys_clk);
    chk(32'({gainStageValid, posIsPin, posIsInternal, irq}), 32'hC);
    rst_b <= 1'h1;
    foreach (rows[i]) begin
      rdr(rows[i].a);
      chk(rd, rows[i].r);
      wr(rows[i].a, 32'hFFFFFFFF);
      rdr(rows[i].a);
      chk(rd, rows[i].e);
    end
    wr(8'h40, 32'h1);
    chk(32'(rs), 32'h2);
    rdr(8'h40);
    chk(32'(rs), 32'h2);
    chk(rd, 32'h0);
    wr(`ADCC_OFF_CONVERSION_CONTROL_B, 32'h110);
    wr(`ADCC_OFF_WINDOW_LOWER_THRESHOLD, 32'h1000);
    wr(`ADCC_OFF_WINDOW_UPPER_THRESHOLD, 32'h2000);
    wr(`ADCC_OFF_INCTRL, 32'h10002);
    wr(`ADCC_OFF_INTMASK, 32'h3);
    for (int m = 0; m < 5; m++) begin
      wr(`ADCC_OFF_WINDOW_MONITOR_CONTROL, 32'(m));
      conv(m == 4);
      chk(32'(positiveInputSelect), 32'(2 + m % 2));
      rdr(`ADCC_OFF_RESULT);
      chk(rd, 32'h800);
      rdr(`ADCC_OFF_INTFLAG);
      chk(rd, {30'h0, hit[m], 1'h1});
      rdr(`ADCC_OFF_SOFTWARE_TRIGGER);
      chk(rd & 32'h2, 32'h0);
      wr(`ADCC_OFF_INTFLAG, 32'h3);
      rdr(`ADCC_OFF_INTFLAG);
      chk({rd[30:0], irq}, 32'h0);
    end
    // Free running with correction, left alignment and an internal input.
    wr(`ADCC_OFF_CONVERSION_CONTROL_B, 32'hF);
    wr(`ADCC_OFF_WINDOW_MONITOR_CONTROL, 32'h1);
    wr(`ADCC_OFF_OFFCAL, 32'h100);
    wr(`ADCC_OFF_GAIN_CALIBRATION_VALUE, 32'h400);
    wr(`ADCC_OFF_INCTRL, 32'h0F000518);
    wr(`ADCC_OFF_SOFTWARE_TRIGGER, 32'h2);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      while (windowHit !== 1'h1 && n < 200) begin
        @(posedge sys_clk);
        n++;
      end
      chk(32'(n < 200), 32'h1);
      wr(`ADCC_OFF_INTFLAG, 32'h3);
    end
    rdr(`ADCC_OFF_RESULT);
    chk(rd, 32'h3800);
    chk(32'({negativeInputSelect, differentialInputSelect, gainStageSel,
             gainStageValid, posIsPin, posIsInternal, positiveInputSelect}),
        32'({5'h05, 1'h1, 4'hF, 3'h5, 5'h18}));
    // A reset in mid-run must bring the gain, input-class, interrupt, start and window outputs back to their idle values.
    rst_b <= 1'h0;
    repeat (3) @(posedge sys_clk);
    chk(32'({gainStageValid, posIsPin, posIsInternal, irq, convStart,
             windowHit}), 32'h30);
    rst_b <= 1'h1;
    rdr(`ADCC_OFF_CONVERSION_CONTROL_B);
    chk(rd, 32'h0);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    summarize();
  end
endmodule
